// File: src/fpes_sequencer.v
// flash program/erase sequencer with unlock, holding latches and core stall
// Functional notes
// - start needs 55h then AAh key writes
// - unlock key register write-only, reads zero
// - stall core while operation runs
// - bit 15 starts operation, hardware clears
// - bit 14 must be set to operate
// - bit 6 selects erase versus program
// - code 0010 erase erases 512-word block
// - code 0001 program writes latch row
// - table writes land in holding latches only
// - address is table page over effective address
`timescale 1ns/1ns
`default_nettype none
`include "fpes_regs.vh"

module fpes_sequencer #(
   parameter [15:0] T_WORD  = `FPES_T_WORD,
   parameter [15:0] T_ROW   = `FPES_T_ROW,
   parameter [15:0] T_BLOCK = `FPES_T_BLOCK
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        reset_n_i,
   // core register access
   input  wire        ctl_wr_i,
   input  wire [15:0] ctl_wdata_i,
   output wire [15:0] ctl_rdata_o,
   input  wire        key_wr_i,
   input  wire [7:0]  key_wdata_i,
   output wire [7:0]  key_rdata_o,
   input  wire        page_wr_i,
   input  wire [7:0]  page_wdata_i,
   output reg  [7:0]  table_page_o,
   // table latch writes
   input  wire        latch_wr_lo_i,
   input  wire        latch_wr_hi_i,
   input  wire [15:0] latch_ea_i,
   input  wire [15:0] latch_data_i,
   // abort of a running operation
   input  wire        abort_i,
   // core stall
   output wire        core_stall_o,
   // flash array port
   output reg         fl_prog_o,
   output reg         fl_erase_o,
   output reg  [23:0] fl_addr_o,
   output reg  [5:0]  fl_idx_o,
   output reg  [23:0] fl_data_o
);

   localparam ST_IDLE = 2'b00;
   localparam ST_RUN  = 2'b01;
   localparam ST_ROW  = 2'b10;

   localparam KEY_NONE = 2'b00;
   localparam KEY_ONE  = 2'b01;
   localparam KEY_OK   = 2'b10;

   reg        start_r;
   reg        permit_r;
   reg        err_r;
   reg        erase_r;
   reg [3:0]  op_r;
   reg [1:0]  key_r;
   reg [1:0]  st_r;
   reg [23:0] addr_r;
   reg [5:0]  idx_r;
   reg [23:0] latch_r [0:`FPES_ROW_WORDS-1];
   reg [15:0] dur;
   reg        valid_op;
   reg        tmr_load;
   wire       tmr_done;
   integer    i;

   // full program address from page and effective address
   function [23:0] fpes_addr;
      input [7:0]  page;
      input [15:0] ea;
      begin
         fpes_addr = {page, ea};
      end
   endfunction

   // decode operation code and select bit into a duration
   always @* begin
      valid_op = 1'b1;
      dur      = T_WORD;
      case ({erase_r, op_r})
         {1'b1, `FPES_OP_BLOCK}: dur = T_BLOCK;
         {1'b0, `FPES_OP_ROW}:   dur = T_ROW;
         {1'b0, `FPES_OP_WORD}:  dur = T_WORD;
         default:                valid_op = 1'b0;
      endcase
   end

   wire start_req = ctl_wr_i && ctl_wdata_i[`FPES_CTL_START_BIT] && !start_r;
   wire start_ok  = start_req && permit_r && (key_r == KEY_OK);

   // register reads; key register always reads zero
   assign ctl_rdata_o = {start_r, permit_r, err_r, 6'h00, erase_r, 2'b00, op_r};
   assign key_rdata_o = 8'h00;
   assign core_stall_o = start_r;

   // key sequencer: only an immediately consecutive pair arms a start
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         key_r <= KEY_NONE;
      end else if (key_wr_i) begin
         if (key_wdata_i == `FPES_KEY_FIRST) begin
            key_r <= KEY_ONE;
         end else if (key_wdata_i == `FPES_KEY_SECOND && key_r == KEY_ONE) begin
            key_r <= KEY_OK;
         end else begin
            key_r <= KEY_NONE;
         end
      end else if (ctl_wr_i || page_wr_i || latch_wr_lo_i || latch_wr_hi_i) begin
         // any other write breaks the pair; the start write itself consumes it
         key_r <= KEY_NONE;
      end
   end

   // control register and operation state machine
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         start_r    <= 1'b0;
         permit_r   <= 1'b0;
         err_r      <= 1'b0;
         erase_r    <= 1'b0;
         op_r       <= 4'h0;
         st_r       <= ST_IDLE;
         idx_r      <= 6'h00;
         fl_prog_o  <= 1'b0;
         fl_erase_o <= 1'b0;
         fl_addr_o  <= 24'h00_0000;
         fl_idx_o   <= 6'h00;
         fl_data_o  <= 24'h00_0000;
         tmr_load   <= 1'b0;
      end else begin
         tmr_load  <= 1'b0;
         fl_prog_o <= 1'b0;
         fl_erase_o <= 1'b0;
         // fields are frozen while an operation runs
         if (ctl_wr_i && !start_r) begin
            permit_r <= ctl_wdata_i[`FPES_CTL_PERMIT_BIT];
            erase_r  <= ctl_wdata_i[`FPES_CTL_ERASE_BIT];
            op_r     <= ctl_wdata_i[`FPES_CTL_OP_HI:`FPES_CTL_OP_LO];
            if (!ctl_wdata_i[`FPES_CTL_ERR_BIT]) begin
               err_r <= 1'b0;
            end
         end
         if (start_req && !start_ok) begin
            err_r <= 1'b1;
         end
         case (st_r)
            ST_IDLE: begin
               if (start_ok) begin
                  start_r <= 1'b1;
                  err_r   <= 1'b0;
                  if (valid_op) begin
                     tmr_load <= 1'b1;
                     st_r     <= (op_r == `FPES_OP_ROW) ? ST_ROW : ST_RUN;
                     idx_r    <= 6'h00;
                  end else begin
                     st_r <= ST_RUN;
                  end
               end
            end
            ST_ROW: begin
               if (abort_i) begin
                  // an abort must not wait for the stream to finish
                  err_r   <= 1'b1;
                  start_r <= 1'b0;
                  st_r    <= ST_IDLE;
               end else begin
                  // stream the latch row to the array while the timer runs
                  fl_prog_o <= 1'b1;
                  fl_addr_o <= {addr_r[23:`FPES_ROW_BITS], {`FPES_ROW_BITS{1'b0}}};
                  fl_idx_o  <= idx_r;
                  fl_data_o <= latch_r[idx_r];
                  idx_r     <= idx_r + 6'h01;
                  if (idx_r == 6'h3F) begin
                     st_r <= ST_RUN;
                  end
               end
            end
            ST_RUN: begin
               if (valid_op && !erase_r && op_r == `FPES_OP_WORD && !tmr_load) begin
                  fl_prog_o <= 1'b0;
               end
               if (abort_i) begin
                  err_r   <= 1'b1;
                  start_r <= 1'b0;
                  st_r    <= ST_IDLE;
               end else if (!valid_op || (tmr_done && !tmr_load)) begin
                  // a done left over from an aborted run must not end a new one
                  if (valid_op && erase_r) begin
                     fl_erase_o <= 1'b1;
                     fl_addr_o  <= {addr_r[23:`FPES_BLOCK_BITS], {`FPES_BLOCK_BITS{1'b0}}};
                  end else if (valid_op && op_r == `FPES_OP_WORD) begin
                     fl_prog_o <= 1'b1;
                     fl_addr_o <= addr_r;
                     fl_idx_o  <= addr_r[`FPES_ROW_BITS-1:0];
                     fl_data_o <= latch_r[addr_r[`FPES_ROW_BITS-1:0]];
                  end
                  start_r <= 1'b0;
                  st_r    <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // table page and latch write address; array is never written here
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         table_page_o <= 8'h00;
         addr_r       <= 24'h00_0000;
      end else begin
         if (page_wr_i) begin
            table_page_o <= page_wdata_i;
         end
         if ((latch_wr_lo_i || latch_wr_hi_i) && !start_r) begin
            addr_r <= fpes_addr(table_page_o, latch_ea_i);
         end
      end
   end

   // latch storage has no reset, as real holding latches power up unknown
   always @(posedge clk_i) begin
      for (i = 0; i < `FPES_ROW_WORDS; i = i + 1) begin
         if (!start_r && i == fpes_addr(table_page_o, latch_ea_i)
                 % `FPES_ROW_WORDS) begin
            if (latch_wr_lo_i) begin
               latch_r[i][15:0] <= latch_data_i;
            end
            if (latch_wr_hi_i) begin
               latch_r[i][23:16] <= latch_data_i[7:0];
            end
         end
      end
   end

   fpes_timer #(
      .CNT_W (16)
   ) u_timer (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .load_i    (tmr_load),
      .count_i   (dur),
      .done_o    (tmr_done)
   );

endmodule // fpes_sequencer

`default_nettype wire

// File: src/fpes_regs.vh
// register layout, key values and operation codes for the flash sequencer
`ifndef FPES_REGS_VH
`define FPES_REGS_VH

// flash_control_reg field positions
`define FPES_CTL_START_BIT   15
`define FPES_CTL_PERMIT_BIT  14
`define FPES_CTL_ERR_BIT     13
`define FPES_CTL_ERASE_BIT   6
`define FPES_CTL_OP_HI       3
`define FPES_CTL_OP_LO       0
`define FPES_CTL_RESET       16'h0000
`define FPES_CTL_WMASK       16'h404F

// unlock key values
`define FPES_KEY_FIRST       8'h55
`define FPES_KEY_SECOND      8'hAA

// operation codes
`define FPES_OP_ROW          4'h1
`define FPES_OP_BLOCK        4'h2
`define FPES_OP_WORD         4'h3

// array geometry
`define FPES_ROW_WORDS       64
`define FPES_ROW_BITS        6
`define FPES_BLOCK_BITS      9
`define FPES_WORD_W          24

// default operation durations in cycles
`define FPES_T_WORD          16'h0040
`define FPES_T_ROW           16'h0100
`define FPES_T_BLOCK         16'h0400

`endif

// File: src/fpes_timer.v
// down-counter that times one flash operation
`timescale 1ns/1ns
`default_nettype none

module fpes_timer #(
   parameter CNT_W = 16
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             reset_n_i,
   // control
   input  wire             load_i,
   input  wire [CNT_W-1:0] count_i,
   // status
   output wire             done_o
);

   reg [CNT_W-1:0] cnt_r;
   reg             run_r;

   // count down while running, done on the last cycle
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= {CNT_W{1'b0}};
         run_r <= 1'b0;
      end else if (load_i) begin
         cnt_r <= count_i;
         run_r <= 1'b1;
      end else if (run_r) begin
         if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
            run_r <= 1'b0;
         end
         cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign done_o = run_r && (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1});

endmodule // fpes_timer

`default_nettype wire

// File: tb/fpes_sequencer_sva.sv
// port-level checks for the flash sequencer
`timescale 1ns/1ns
`default_nettype none
module fpes_sequencer_sva (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   // core side
   input wire logic        ctl_wr_i,
   input wire logic [15:0] ctl_wdata_i,
   input wire logic [15:0] ctl_rdata_o,
   input wire logic        key_wr_i,
   input wire logic [7:0]  key_wdata_i,
   input wire logic [7:0]  key_rdata_o,
   input wire logic        abort_i,
   input wire logic        core_stall_o,
   // flash side
   input wire logic        fl_prog_o,
   input wire logic        fl_erase_o,
   input wire logic [23:0] fl_addr_o,
   input wire logic [5:0]  fl_idx_o
);
   logic [7:0] k_prev;
   logic [7:0] k_last;
   // last two key bytes; only the key strobe moves them
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         k_prev <= 8'h00;
         k_last <= 8'h00;
      end else if (key_wr_i) begin
         k_prev <= k_last;
         k_last <= key_wdata_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_key_write_only: assert property (key_rdata_o == 8'h00) else $error("key readback");
   a_start_needs_keys: assert property ($rose(core_stall_o) |-> $past(ctl_wr_i)
      && $past(ctl_wdata_i[15]) && k_prev == 8'h55 && k_last == 8'hAA) else $error("keyless start");
   a_start_needs_permit: assert property ($rose(core_stall_o) |-> $past(ctl_rdata_o[14]))
      else $error("start without permit");
   a_stall_is_start: assert property (core_stall_o == ctl_rdata_o[15])
      else $error("stall and start differ");
   a_refused_sets_err: assert property (ctl_wr_i && ctl_wdata_i[15] && !ctl_rdata_o[15]
      && !ctl_rdata_o[14] |=> ctl_rdata_o[13] && !core_stall_o) else $error("refusal unflagged");
   a_abort_ends_op: assert property (core_stall_o && abort_i
      |-> ##[1:2] (!core_stall_o && ctl_rdata_o[13])) else $error("abort ignored");
   a_erase_aligned: assert property (fl_erase_o |-> fl_addr_o[8:0] == 9'h000)
      else $error("erase unaligned");
   a_idx_steps_up: assert property (fl_prog_o && $past(fl_prog_o)
      |-> fl_idx_o == $past(fl_idx_o) + 6'h01) else $error("latch index skipped");
   c_started: cover property ($rose(core_stall_o));
   c_erased: cover property (fl_erase_o);
   c_aborted: cover property (core_stall_o && abort_i);
endmodule // fpes_sequencer_sva
bind fpes_sequencer fpes_sequencer_sva u_sva (.*);
`default_nettype wire

// File: tb/fpes_core_model.sv
// core-side model issuing register and table writes
`timescale 1ns/1ns
`default_nettype none
module fpes_core_model (
   // clock
   input  wire logic        clk_i,
   // write strobes
   output var  logic        ctl_wr_o,
   output var  logic        key_wr_o,
   output var  logic        page_wr_o,
   output var  logic        lo_wr_o,
   output var  logic        hi_wr_o,
   // address, shared data, abort
   output var  logic [15:0] ea_o,
   output var  logic [15:0] wd_o,
   output var  logic        abort_o
);
   initial begin
      {ctl_wr_o, key_wr_o, page_wr_o, lo_wr_o, hi_wr_o, abort_o} = 6'h00;
      ea_o = 16'h0000;
      wd_o = 16'h0000;
   end
   // one write cycle; data turns over after so a stale value never passes
   task wr(input integer k, input [15:0] a, input [15:0] d);
      begin
         @(negedge clk_i);
         ea_o = a;
         wd_o = d;
         {ctl_wr_o, key_wr_o, page_wr_o, lo_wr_o, hi_wr_o} = 5'h10 >> k;
         @(negedge clk_i);
         {ctl_wr_o, key_wr_o, page_wr_o, lo_wr_o, hi_wr_o} = 5'h00;
         wd_o = ~d;
      end
   endtask
   // configure, unlock, start; no interrupt can split the key pair here
   task start_op(input [15:0] c);
      begin
         wr(0, 16'h0000, c);
         wr(1, 16'h0000, 16'h0055);
         wr(1, 16'h0000, 16'h00AA);
         wr(0, 16'h0000, c | 16'h8000);
         repeat (2) @(negedge clk_i);
      end
   endtask
   // one-cycle abort request, raised and dropped off the edge
   task abort_pulse;
      begin
         @(negedge clk_i);
         abort_o = 1'b1;
         @(negedge clk_i);
         abort_o = 1'b0;
      end
   endtask
   // one instruction word: low word then high byte
   task latch(input [15:0] a, input [23:0] w);
      begin
         wr(3, a, w[15:0]);
         wr(4, a, {8'h00, w[23:16]});
      end
   endtask
endmodule // fpes_core_model
`default_nettype wire

// File: tb/tb_flash_program_erase_sequencer.sv
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_flash_program_erase_sequencer;
   reg         clk_i = 1'b0;
   reg         reset_n_i = 1'b0;
   wire        c_wr, k_wr, p_wr, lo_wr, hi_wr, abort, stall, prog, erase;
   wire [15:0] ea, wd, rd;
   wire [7:0]  krd;
   wire [7:0]  pg;
   integer     r;
   wire [5:0]  idx;
   wire [23:0] addr, data;
   integer     n_errors = 0;
   integer     cmp_count = 0;
   integer     n_prog = 0;
   integer     n_erase = 0;
   reg  [23:0] l_addr, l_data;
   reg  [5:0]  l_idx;
   always #50 clk_i = ~clk_i;
   fpes_core_model core (.clk_i(clk_i), .ctl_wr_o(c_wr), .key_wr_o(k_wr), .page_wr_o(p_wr),
      .lo_wr_o(lo_wr), .hi_wr_o(hi_wr), .ea_o(ea), .wd_o(wd), .abort_o(abort));
   // short counts keep the run brief; row must outlast its 64 latch cycles
   fpes_sequencer #(.T_WORD(16'h0010), .T_ROW(16'h0050), .T_BLOCK(16'h0028)) dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ctl_wr_i(c_wr), .ctl_wdata_i(wd),
      .ctl_rdata_o(rd), .key_wr_i(k_wr), .key_wdata_i(wd[7:0]), .key_rdata_o(krd),
      .page_wr_i(p_wr), .page_wdata_i(wd[7:0]), .table_page_o(pg), .latch_wr_lo_i(lo_wr),
      .latch_wr_hi_i(hi_wr), .latch_ea_i(ea), .latch_data_i(wd), .abort_i(abort),
      .core_stall_o(stall), .fl_prog_o(prog), .fl_erase_o(erase), .fl_addr_o(addr),
      .fl_idx_o(idx), .fl_data_o(data));
   // log of flash array strokes
   always @(posedge clk_i) begin
      if (prog | erase) begin
         n_prog <= n_prog + prog;
         n_erase <= n_erase + erase;
         {l_addr, l_data, l_idx} <= {addr, data, idx};
      end
   end
   task chk(input [23:0] got, input [23:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task conclude;
      begin
         $display("errors %0d comparisons %0d", n_errors, cmp_count);
         if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // bounded wait for the stall to drop
   task wait_idle;
      integer i;
      begin
         for (i = 0; i < 300 && stall !== 1'b0; i = i + 1)
            @(negedge clk_i);
         chk(stall, 24'h0);
         if (stall !== 1'b0)
            conclude;
         // one more edge so the log catches the closing stroke
         @(negedge clk_i);
         n_prog = 0;
         n_erase = 0;
      end
   endtask
   task t_reset;
      begin
         chk(rd, 24'h0);
         chk(krd, 24'h0);
      end
   endtask
   task t_permit;
      begin
         core.start_op(16'h0001);
         chk(rd, 24'h2001);
      end
   endtask
   task t_badkey;
      begin
         core.wr(0, 16'h0000, 16'h4001);
         core.wr(1, 16'h0000, 16'h0055);
         core.wr(1, 16'h0000, 16'h0000);
         core.wr(1, 16'h0000, 16'h00AA);
         core.wr(0, 16'h0000, 16'hC001);
         @(negedge clk_i);
         chk(rd, 24'h6001);
      end
   endtask
   task t_word;
      begin
         core.wr(2, 16'h0000, 16'h0012);
         chk(pg, 24'h12);
         core.latch(16'h3456, 24'hAB_CDEF);
         chk(n_prog, 24'h0);
         core.start_op(16'h4003);
         core.wr(0, 16'h0000, 16'h4003);
         chk(stall, 24'h1);
         wait_idle;
         chk(l_addr, 24'h12_3456);
         chk(l_data, 24'hAB_CDEF);
         chk(rd, 24'h4003);
         chk(krd, 24'h0);
      end
   endtask
   // one row of the erased block, r counts rows from the block base
   task t_row(input integer r);
      integer i;
      begin
         for (i = 0; i < 64; i = i + 1)
            core.latch(16'h0200 + 16'h0040 * r[15:0] + i[15:0],
               {8'h5A + r[7:0], i[7:0], 8'hC3});
         core.start_op(16'h4001);
         @(negedge clk_i);
         for (i = 0; i < 300 && stall === 1'b1; i = i + 1) begin
            @(negedge clk_i);
            if (n_prog == 64) begin
               chk(l_idx, 24'h3F);
               chk(l_data, {8'h5A + r[7:0], 8'h3F, 8'hC3});
            end
         end
         chk(n_prog, 24'h40);
         chk(l_addr, 24'h01_0200 + 24'h40 * r[23:0]);
         wait_idle;
      end
   endtask
   task t_erase;
      integer i;
      begin
         core.wr(2, 16'h0000, 16'h0001);
         core.latch(16'h0345, 24'h00_0000);
         core.start_op(16'h4042);
         @(negedge clk_i);
         // the stroke is logged one edge after the stall drops
         for (i = 0; i < 300 && n_erase == 0; i = i + 1)
            @(negedge clk_i);
         chk(n_erase, 24'h1);
         chk(l_addr, 24'h01_0200);
         wait_idle;
      end
   endtask
   task t_nop;
      integer i;
      reg [63:0] codes;
      begin
         codes = 64'h4041_4043_4002_4007;
         for (i = 0; i < 4; i = i + 1) begin
            core.start_op(codes[63-16*i -: 16]);
            repeat (4) @(negedge clk_i);
            chk(n_prog + n_erase, 24'h0);
            chk(rd, {8'h00, codes[63-16*i -: 16]});
            wait_idle;
         end
      end
   endtask
   task t_abort;
      begin
         core.start_op(16'h4042);
         core.abort_pulse;
         chk(n_erase, 24'h0);
         wait_idle;
         chk(rd, 24'h6042);
         // abort in the middle of a row stream
         core.start_op(16'h4001);
         core.abort_pulse;
         wait_idle;
         chk(rd, 24'h6001);
      end
   endtask
   // main sequence; reset held two cycles, released off the edge
   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      reset_n_i = 1'b1;
      t_reset;
      t_permit;
      t_badkey;
      t_word;
      t_erase;
      for (r = 0; r < 8; r = r + 1)
         t_row(r);
      t_nop;
      t_abort;
      conclude;
   end
endmodule // tb_flash_program_erase_sequencer
`default_nettype wire
